// [rtl/sbcs_pkg.sv]
package sbcs_pkg;
  localparam int ADDR_W = 28;
  localparam int DATA_W = 32;
  localparam int LANES  = 4;
  localparam int NUM_CS = 5;
  localparam int MODE_W = 2;
  localparam int WAIT_W = 4;
  localparam int CNT_W  = 8;

  localparam logic [MODE_W-1:0] MODE_PLAIN = 2'h0;
  localparam logic [MODE_W-1:0] MODE_PAGE  = 2'h1;
  localparam logic [MODE_W-1:0] MODE_SDRAM = 2'h2;

  localparam logic [NUM_CS-1:0] BOOT_SELECT = 5'h01;
  localparam logic [WAIT_W-1:0] BOOT_WAIT   = 4'hf;
  localparam logic [CNT_W-1:0]  UNMAPPED_TIMEOUT = 8'h3f;

  // column strobe patterns, bit 3 highest strobe
  localparam logic [3:0] STROBES_IDLE = 4'hf;
  localparam logic [3:0] SD_ACTIVATE  = 4'h7;
  localparam logic [3:0] SD_READ_AP   = 4'hb;
  localparam logic [3:0] SD_WRITE_AP  = 4'h9;
  localparam logic [3:0] SD_NOP       = 4'hf;

  localparam logic       RST_BUS_CLK = 1'b0;
  localparam logic [2:0] RST_SYNC    = 3'h7;

  typedef enum logic [2:0] {
    S_IDLE,
    S_ADDR,
    S_WAIT,
    S_ACK,
    S_REL
  } sbcs_state_e;
endpackage : sbcs_pkg

// [rtl/sbcs_port.sv]
`timescale 1ns/10ps
module sbcs_port #(
  parameter logic [7:0] TIMEOUT = sbcs_pkg::UNMAPPED_TIMEOUT
) (
  // clock and reset
  input  wire logic                     ref_clk,
  input  wire logic                     rst_n,
  // request side
  input  wire logic                     req_valid,
  input  wire logic                     req_write,
  input  wire logic [27:0]              req_addr,
  input  wire logic [31:0]              req_wdata,
  input  wire logic [3:0]               req_lanes,
  output logic                          req_ready,
  output logic                          rsp_valid,
  output logic [31:0]                   rsp_rdata,
  output logic                          rsp_error,
  output logic                          rsp_burst_end,
  // region configuration
  input  wire logic                     config_done,
  input  wire logic [4:0]               cs_enable,
  input  wire logic [139:0]             cs_base,
  input  wire logic [139:0]             cs_mask,
  input  wire logic [9:0]               cs_mode,
  input  wire logic [19:0]              cs_wait,
  // bus clock
  output logic                          bus_clk,
  // address, data, lanes, direction
  input  wire logic [27:0]              addr_in,
  output logic [27:0]                   addr_out,
  output logic                          addr_oe,
  input  wire logic [31:0]              data_in,
  output logic [31:0]                   data_out,
  output logic                          data_oe,
  input  wire logic [3:0]               byte_lane_select_n_in,
  output logic [3:0]                    byte_lane_select_n_out,
  output logic                          byte_lane_select_oe,
  input  wire logic                     rw_in,
  output logic                          rw_out,
  output logic                          rw_oe,
  // termination
  input  wire logic                     cycle_ack_n_in,
  output logic                          cycle_ack_n_out,
  output logic                          cycle_ack_oe,
  input  wire logic                     error_ack_n_in,
  output logic                          error_ack_n_out,
  output logic                          error_ack_oe,
  // selects and strobes
  output logic                          boot_select_n,
  output logic                          region_select1_n,
  output logic                          region_select2_n,
  output logic                          region_select3_n,
  output logic                          region_select4_n,
  output logic                          col_strobe0_n,
  output logic                          col_strobe1_n,
  output logic                          col_strobe2_n,
  output logic                          col_strobe3_n,
  output logic                          write_strobe_n,
  output logic                          read_strobe_n
);
  localparam int AW = sbcs_pkg::ADDR_W;
  localparam int NC = sbcs_pkg::NUM_CS;
  localparam int MW = sbcs_pkg::MODE_W;
  localparam int WW = sbcs_pkg::WAIT_W;
  localparam int CW = sbcs_pkg::CNT_W;

  sbcs_pkg::sbcs_state_e state;
  sbcs_pkg::sbcs_state_e next_state;

  logic [NC-1:0] sel;
  logic [NC-1:0] cs_n;
  logic [MW-1:0] mode;
  logic [CW-1:0] cnt;
  logic [3:0]    col_n;
  logic [2:0]    ack_s;
  logic [2:0]    err_s;
  logic          ack_lvl;
  logic          err_lvl;

  // other masters never exist, so sensed address, lane and direction levels go unused
  wire unused_in = ^{addr_in, byte_lane_select_n_in, rw_in};

  // region decode, lowest index wins
  // overlapping regions are legal; priority keeps one select low
  logic [NC-1:0] cs_hit;
  logic [MW-1:0] mode_acc [0:NC];
  logic [WW-1:0] wait_acc [0:NC];
  wire  [NC-1:0] first_hit = cs_hit & NC'(~cs_hit + NC'(1));
  assign mode_acc[0] = '0;
  assign wait_acc[0] = '0;
  genvar gi;
  generate
    for (gi = 0; gi < NC; gi++)
    begin : g_dec
      assign cs_hit[gi] = cs_enable[gi] &
        (((req_addr ^ cs_base[gi*AW +: AW]) & cs_mask[gi*AW +: AW]) == '0);
      assign mode_acc[gi+1] = mode_acc[gi] |
        ({MW{first_hit[gi]}} & cs_mode[gi*MW +: MW]);
      assign wait_acc[gi+1] = wait_acc[gi] |
        ({WW{first_hit[gi]}} & cs_wait[gi*WW +: WW]);
    end
  endgenerate

  // before configuration every access goes to the boot device
  wire [NC-1:0] pick_sel  = config_done ? first_hit
                                        : sbcs_pkg::BOOT_SELECT;
  wire [MW-1:0] pick_mode = config_done ? mode_acc[NC]
                                        : sbcs_pkg::MODE_PLAIN;
  wire [WW-1:0] pick_wait = config_done ? wait_acc[NC]
                                        : sbcs_pkg::BOOT_WAIT;

  // launch on edges where bus_clk falls; far end samples on its rise
  wire tick  = bus_clk;
  wire taken = req_valid & req_ready;
  wire ack_on = ~ack_lvl;
  wire err_on = ~err_lvl;
  wire ext_term = ack_on | err_on;
  // no select hit means nobody will answer the cycle
  wire mapped = |sel;

  // states advance only at launch edges; ADDR, ACK and REL last one bus tick each
  always_comb
  begin
    next_state = state;
    if (tick)
      case (state)
        sbcs_pkg::S_IDLE: if (taken) next_state = sbcs_pkg::S_ADDR;
        sbcs_pkg::S_ADDR: next_state = sbcs_pkg::S_WAIT;
        sbcs_pkg::S_WAIT:
          if (ext_term)
            next_state = sbcs_pkg::S_REL;
          else if (cnt == '0)
            next_state = sbcs_pkg::S_ACK;
        sbcs_pkg::S_ACK:  next_state = sbcs_pkg::S_REL;
        sbcs_pkg::S_REL:  next_state = sbcs_pkg::S_IDLE;
        default:          next_state = sbcs_pkg::S_IDLE;
      endcase
  end

  wire [NC-1:0] next_sel   = taken ? pick_sel : sel;
  wire [MW-1:0] next_mode  = taken ? pick_mode : mode;
  wire          next_wr    = taken ? req_write : ~rw_out;
  wire [3:0]    next_lanes_n = taken ? ~req_lanes : byte_lane_select_n_out;
  wire          next_mapped = |next_sel;
  wire next_in_cycle = (next_state == sbcs_pkg::S_ADDR) ||
                       (next_state == sbcs_pkg::S_WAIT);
  wire next_strobe = next_state == sbcs_pkg::S_WAIT;
  wire next_drive  = next_state != sbcs_pkg::S_IDLE;
  wire next_ack_low = next_state == sbcs_pkg::S_ACK;
  // own driver stays on one extra bus tick to pull the line high
  wire next_own = next_ack_low || (next_state == sbcs_pkg::S_REL &&
                                   state == sbcs_pkg::S_ACK);
  wire [NC-1:0] next_cs_n = ~(next_sel & {NC{next_in_cycle}});

  // column strobe selection by region mode
  // sdram cycles always close with auto precharge, so no open row
  // is tracked; the price is an activate on every access
  wire sd_cmd_slot = next_strobe && state == sbcs_pkg::S_ADDR;
  wire [3:0] sd_cmd =
    (next_state == sbcs_pkg::S_ADDR) ? sbcs_pkg::SD_ACTIVATE :
    sd_cmd_slot ? (next_wr ? sbcs_pkg::SD_WRITE_AP
                           : sbcs_pkg::SD_READ_AP)
                : sbcs_pkg::SD_NOP;
  wire [3:0] page_n = next_strobe ? next_lanes_n
                                  : sbcs_pkg::STROBES_IDLE;
  wire [3:0] next_col_n =
    !next_mapped ? sbcs_pkg::STROBES_IDLE :
    (next_mode == sbcs_pkg::MODE_SDRAM) ? sd_cmd :
    (next_mode == sbcs_pkg::MODE_PAGE)  ? page_n
                                        : sbcs_pkg::STROBES_IDLE;

  // three-stage sync on the sensed terminations; a change counts
  // only once stages two and three agree, so a glitch is dropped
  always_ff @(posedge ref_clk)
  begin
    if (!rst_n)
    begin
      ack_s   <= sbcs_pkg::RST_SYNC;
      err_s   <= sbcs_pkg::RST_SYNC;
      ack_lvl <= 1'b1;
      err_lvl <= 1'b1;
    end
    else
    begin
      ack_s <= {ack_s[1:0], cycle_ack_n_in};
      err_s <= {err_s[1:0], error_ack_n_in};
      if (ack_s[1] == ack_s[2])
        ack_lvl <= ack_s[2];
      if (err_s[1] == err_s[2])
        err_lvl <= err_s[2];
    end
  end

  // ready only in the cycle before a launch edge, so a taken
  // request always lands on the edge that starts the address tick
  always_ff @(posedge ref_clk)
  begin
    if (!rst_n)
    begin
      bus_clk   <= sbcs_pkg::RST_BUS_CLK;
      state     <= sbcs_pkg::S_IDLE;
      req_ready <= 1'b0;
      rsp_valid <= 1'b0;
    end
    else
    begin
      bus_clk   <= ~bus_clk;
      req_ready <= (next_state == sbcs_pkg::S_IDLE) & ~bus_clk;
      rsp_valid <= tick & (state == sbcs_pkg::S_REL);
      state     <= next_state;
    end
  end

  // pin drivers, updated only at launch edges
  // strobes and selects settle half a bus tick before the far end
  // samples them on the rising bus clock
  always_ff @(posedge ref_clk)
  begin
    if (!rst_n)
    begin
      cs_n                <= '1;
      col_n               <= sbcs_pkg::STROBES_IDLE;
      write_strobe_n      <= 1'b1;
      read_strobe_n       <= 1'b1;
      addr_oe             <= 1'b0;
      byte_lane_select_oe <= 1'b0;
      rw_oe               <= 1'b0;
      data_oe             <= 1'b0;
      cycle_ack_oe        <= 1'b0;
      cycle_ack_n_out     <= 1'b1;
      error_ack_oe        <= 1'b0;
      error_ack_n_out     <= 1'b1;
    end
    else if (tick)
    begin
      cs_n           <= next_cs_n;
      col_n          <= next_col_n;
      write_strobe_n <= ~(next_strobe & next_mapped & next_wr);
      read_strobe_n  <= ~(next_strobe & next_mapped & ~next_wr);
      addr_oe             <= next_drive;
      byte_lane_select_oe <= next_drive;
      rw_oe               <= next_drive;
      // write data stays driven through the acknowledge tick so a
      // late sampling peripheral still sees the word
      data_oe <= next_wr & (next_strobe ||
                            next_state == sbcs_pkg::S_ACK);
      cycle_ack_oe    <= next_own & mapped;
      cycle_ack_n_out <= ~(next_ack_low & mapped);
      error_ack_oe    <= next_own & ~mapped;
      error_ack_n_out <= ~(next_ack_low & ~mapped);
    end
  end

  // cycle fields and result capture
  // an unmapped cycle has nobody to answer it, so the port ends it
  // itself with an error after the timeout rather than hanging
  // read data is taken unsynchronised at the terminating edge;
  // the peripheral must hold it while the read strobe is low
  always_ff @(posedge ref_clk)
  begin
    if (!rst_n)
    begin
      sel                    <= '0;
      mode                   <= sbcs_pkg::MODE_PLAIN;
      cnt                    <= '0;
      addr_out               <= '0;
      data_out               <= '0;
      byte_lane_select_n_out <= '1;
      rw_out                 <= 1'b1;
      rsp_rdata              <= '0;
      rsp_error              <= 1'b0;
      rsp_burst_end          <= 1'b0;
    end
    else if (taken)
    begin
      sel      <= pick_sel;
      mode     <= pick_mode;
      cnt      <= (|pick_sel) ? CW'(pick_wait) : TIMEOUT;
      addr_out <= req_addr;
      data_out <= req_wdata;
      byte_lane_select_n_out <= ~req_lanes;
      rw_out   <= ~req_write;
    end
    else if (tick && state == sbcs_pkg::S_WAIT)
    begin
      if (next_state != sbcs_pkg::S_WAIT)
      begin
        rsp_rdata     <= data_in;
        rsp_error     <= ext_term ? (err_on & ~ack_on) : ~mapped;
        rsp_burst_end <= ext_term & err_on & ack_on;
      end
      else
        cnt <= cnt - CW'(1);
    end
  end

  // pins come straight from the select and strobe registers
  assign boot_select_n    = cs_n[0];
  assign region_select1_n = cs_n[1];
  assign region_select2_n = cs_n[2];
  assign region_select3_n = cs_n[3];
  assign region_select4_n = cs_n[4];
  assign col_strobe0_n    = col_n[0];
  assign col_strobe1_n    = col_n[1];
  assign col_strobe2_n    = col_n[2];
  assign col_strobe3_n    = col_n[3];
endmodule : sbcs_port

// [testbench/sbcs_props.sv]
`timescale 1ns/10ps
module sbcs_props (
  // watched top-level ports
  input logic        ref_clk, rst_n, config_done, bus_clk, rsp_valid,
  input logic [27:0] addr_out,
  input logic        addr_oe, data_oe, byte_lane_select_oe, rw_out, rw_oe,
  input logic        cycle_ack_n_out, cycle_ack_oe,
  input logic        error_ack_n_out, error_ack_oe,
  input logic        boot_select_n, region_select1_n, region_select2_n,
  input logic        region_select3_n, region_select4_n,
  input logic        read_strobe_n, write_strobe_n,
  input logic        col_strobe0_n, col_strobe1_n,
  input logic        col_strobe2_n, col_strobe3_n
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  wire [3:0] col = {col_strobe3_n, col_strobe2_n, col_strobe1_n,
                    col_strobe0_n};
  wire [3:0] rgn = {region_select4_n, region_select3_n, region_select2_n,
                    region_select1_n};
  a_plain_col_idle: assert property (!config_done |-> col == 4'hf)
    else $error("column strobe active in boot mode");
  a_boot_only: assert property (!config_done |-> &rgn)
    else $error("region select before configuration");
  a_write_dir: assert property (!write_strobe_n |->
    rw_oe && !rw_out && read_strobe_n) else $error("write strobe misuse");
  a_read_dir: assert property (!read_strobe_n |->
    rw_oe && rw_out && !data_oe) else $error("read strobe misuse");
  a_data_on_write: assert property (data_oe |->
    addr_oe && rw_oe && !rw_out) else $error("data driven off write");
  a_drivers_release: assert property (!rw_oe |->
    !addr_oe && !data_oe && !byte_lane_select_oe)
    else $error("bus driven while released");
  a_ack_high_release: assert property ($fell(cycle_ack_oe) |->
    $past(cycle_ack_n_out)) else $error("ack released while low");
  a_err_high_release: assert property ($fell(error_ack_oe) |->
    $past(error_ack_n_out)) else $error("error released while low");
  a_ack_ends_cycle: assert property (cycle_ack_oe && !cycle_ack_n_out
    |-> ##[1:8] rsp_valid) else $error("ack without completion");
  a_launch_edge: assert property ($changed({addr_out, read_strobe_n,
    write_strobe_n}) |-> $fell(bus_clk)) else $error("change off bus edge");
endmodule : sbcs_props
bind sbcs_port sbcs_props i_props (.*);

// [testbench/sbcs_mem_model.sv]
`timescale 1ns/10ps
module sbcs_mem_model (
  // bus side
  input  logic        bus_clk, data_oe, read_strobe_n, write_strobe_n,
  input  logic [27:0] addr_out,
  input  logic [31:0] data_out,
  input  logic [3:0]  lanes_n,
  // bench command: bit0 ack, bit1 error
  input  logic [1:0]  ext_mode,
  output logic [31:0] m_data,
  output logic        m_oe, m_ack_oe, m_ack_n, m_err_oe, m_err_n
);
  logic [31:0] mem [16];
  logic [1:0]  cnt = 2'h0;
  logic        low = 1'h0;
  logic        high = 1'h0;
  wire         act = !read_strobe_n || !write_strobe_n;
  wire [3:0]   idx = addr_out[5:2];
  initial foreach (mem[i]) mem[i] = 32'h0;
  // no hold past the strobe, as a real part
  assign m_oe = !read_strobe_n;
  assign m_data = mem[idx];
  // low from the third strobed tick, then high one tick before release
  assign m_ack_oe = ext_mode[0] && (low || high);
  assign m_err_oe = ext_mode[1] && (low || high);
  assign m_ack_n = !low;
  assign m_err_n = !low;
  always @(posedge bus_clk)
  begin
    cnt <= act ? cnt + {1'h0, cnt != 2'h3} : 2'h0;
    low <= act && cnt >= 2'h2;
    high <= low;
    for (int b = 0; b < 4; b++)
      if (!write_strobe_n && data_oe && !lanes_n[b])
        mem[idx][b*8+:8] <= data_out[b*8+:8];
  end
endmodule : sbcs_mem_model

// [testbench/tb_top.sv]
`timescale 1ns/10ps
module tb_top;
  typedef struct packed {
    logic w; logic [27:0] a; logic [31:0] d;
    logic [3:0] l, col; logic [4:0] sel; logic err;
  } sbcs_row_s;
  logic ref_clk = 1'h0, rst_n = 1'h0, req_valid = 1'h0, req_write = 1'h0;
  logic config_done = 1'h0;
  logic [27:0] req_addr = 28'h0;
  logic [31:0] req_wdata = 32'h0;
  logic [3:0] req_lanes = 4'hf;
  logic [1:0] ext_mode = 2'h0;
  logic req_ready, rsp_valid, rsp_error, rsp_burst_end, bus_clk, addr_oe;
  logic [31:0] rsp_rdata, data_out, m_data;
  logic [27:0] addr_out;
  logic [3:0] byte_lane_select_n_out;
  logic data_oe, byte_lane_select_oe, rw_out, rw_oe, cycle_ack_n_out;
  logic cycle_ack_oe, error_ack_n_out, error_ack_oe, boot_select_n;
  logic region_select1_n, region_select2_n, region_select3_n;
  logic region_select4_n, col_strobe0_n, col_strobe1_n, col_strobe2_n;
  logic col_strobe3_n, write_strobe_n, read_strobe_n;
  logic m_oe, m_ack_oe, m_ack_n, m_err_oe, m_err_n;
  logic [10:0] seen;
  int n_mismatch = 0, samples_checked = 0, lat;
  wire [4:0] cs_enable = 5'h1e;
  wire [139:0] cs_base = {28'h4000000, 28'h3000000, 28'h2000000,
                          28'h1000000, 28'h0};
  wire [139:0] cs_mask = {5{28'hf000000}};
  wire [9:0] cs_mode = 10'h090;
  wire [19:0] cs_wait = 20'hf2100;
  // released lines: pull-ups where fitted, else inverted
  wire [31:0] data_in = m_oe ? m_data : data_oe ? data_out : '1;
  wire [27:0] addr_in = addr_oe ? addr_out : ~addr_out;
  wire [3:0] byte_lane_select_n_in = byte_lane_select_oe ?
    byte_lane_select_n_out : ~byte_lane_select_n_out;
  wire rw_in = rw_oe ? rw_out : ~rw_out;
  wire cycle_ack_n_in = cycle_ack_oe ? cycle_ack_n_out : !m_ack_oe | m_ack_n;
  wire error_ack_n_in = error_ack_oe ? error_ack_n_out : !m_err_oe | m_err_n;
  wire [8:0] sc_n = {region_select4_n, region_select3_n, region_select2_n,
    region_select1_n, boot_select_n, col_strobe3_n, col_strobe2_n,
    col_strobe1_n, col_strobe0_n};
  wire [20:0] idle = {sc_n, write_strobe_n, read_strobe_n, rw_out, addr_oe,
    data_oe, byte_lane_select_oe, rw_oe, cycle_ack_oe, error_ack_oe,
    bus_clk, req_ready, rsp_valid};
  sbcs_row_s rows [9] = '{
    '{1, 'h1000000, 'h11223344, 'hf, 0, 'h02, 0},
    '{0, 'h1000000, 'h11223344, 'hf, 0, 'h02, 0},
    '{1, 'h1000000, 'haabbccdd, 'h5, 0, 'h02, 0},
    '{0, 'h1000000, 'h11bb33dd, 'hf, 0, 'h02, 0},
    '{1, 'h2000008, 'h55667788, 'h3, 'h3, 'h04, 0},
    '{0, 'h2000008, 'h7788, 'hc, 'hc, 'h04, 0},
    '{1, 'h300000c, 'hbadf00d, 'hf, 'he, 'h08, 0},
    '{0, 'h300000c, 'hbadf00d, 'hf, 'hc, 'h08, 0},
    '{0, 'h7000000, 0, 'hf, 0, 0, 1}};
  sbcs_port #(.TIMEOUT(8'h04)) i_dut (.*);
  sbcs_mem_model i_mem (.lanes_n(byte_lane_select_n_out), .*);
  always #25 ref_clk = ~ref_clk;
  task automatic chk(input string n, input logic [31:0] got, exp);
    samples_checked++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("[ERR] %s expected %h seen %h", n, exp, got);
    end
  endtask : chk
  task automatic end_sim;
    $display("checks %0d mismatches %0d", samples_checked, n_mismatch);
    if (n_mismatch == 0 && samples_checked > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : end_sim
  // hold request until taken, bounded waits throughout
  task automatic run(input sbcs_row_s r);
    int i;
    seen = '0;
    {req_write, req_addr, req_wdata, req_lanes} = {r.w, r.a, r.d, r.l};
    req_valid = 1'h1;
    for (i = 0; i < 200 && req_ready !== 1'h1; i++) @(posedge ref_clk) #1;
    @(posedge ref_clk) #1;
    req_valid = 1'h0;
    // pins stand at least two ref cycles, so one sample each misses none
    for (lat = 0; lat < 200 && rsp_valid !== 1'h1; lat++)
    begin
      @(posedge ref_clk) #1;
      seen = seen | ~{sc_n, write_strobe_n, read_strobe_n};
    end
    if (i == 200 || lat == 200)
    begin
      n_mismatch++;
      end_sim;
    end
  endtask : run
  task automatic run_chk(input sbcs_row_s r);
    logic [10:0] e;
    e = {r.sel, r.col, r.w & !r.err, !r.w & !r.err};
    run(r);
    chk("strobes", seen, e);
    chk("error", rsp_error, r.err);
    if (!r.w && !r.err) chk("rdata", rsp_rdata, r.d);
  endtask : run_chk
  initial
  begin
    repeat (10) @(posedge ref_clk);
    #1;
    chk("reset", idle, 21'h1ffe00);
    rst_n = 1'h1;
    run_chk('{0, 'h10, 0, 'hf, 0, 'h01, 0});
    config_done = 1'h1;
    foreach (rows[k]) run_chk(rows[k]);
    for (int m = 1; m < 4; m++)
    begin
      ext_mode = m[1:0];
      run('{0, 'h4000010, 0, 'hf, 0, 'h10, 0});
      chk("ext error", rsp_error, m == 2);
      chk("ext burst", rsp_burst_end, m == 3);
      chk("ext early", lat < 2 * (4 + 15), 1'h1);
    end
    ext_mode = 2'h0;
    req_valid = 1'h1;
    repeat (6) @(posedge ref_clk);
    #1;
    rst_n = 1'h0;
    req_valid = 1'h0;
    repeat (2) @(posedge ref_clk);
    #1;
    chk("mid reset", idle, 21'h1ffe00);
    rst_n = 1'h1;
    run_chk(rows[3]);
    end_sim;
  end
endmodule : tb_top
